// ### core/mic_intensity_top.sv
`timescale 1ns/1ps
// What this block does
// - A write to address 0x0e stores bits 7..4 as the master level and bits 3..0 as the aux level.
// - A read of that address returns both stored nibbles unchanged in the same positions.
// - Master level zero turns the pwm off, so each output drives its out_level bit statically.
// - While the master level is zero the pwm oscillator stops and every output is static.
// - A master level n from 1 to 15 gives a master duty of n/15, with 15 meaning full.
// - An aux level n from 0 to 14 drives the seventeenth output on (n+1) of 16 sub-steps in each open master slot.
// - An aux level of all ones drives the seventeenth output static at 16/16 with no pwm.
// - Omitted legacy features come up from reset in the legacy default, pwm stopped.
// - The pwm features live only at their new address and leave every other address alone.
// - With the global flag set, the aux nibble replaces every individual output level.
// - Under global control master and aux nibbles form one 240-step control for all outputs.
module mic_intensity_top
    import mic_pkg::*;
#(
    parameter int PORTS = PORT_COUNT
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [mic_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_rd,
    output logic [mic_pkg::DATA_W-1:0]         reg_rdata,
    output logic                               reg_rvalid,
    output logic                               reg_hit,
    input  wire logic                          global_enable,
    input  wire logic [PORTS*4-1:0]            port_level,
    input  wire logic [PORTS:0]                out_level,
    output logic [PORTS-1:0]                   port_drive,
    output logic                               seventeenth_output,
    output logic                               pwm_running,
    output logic [3:0]                         master_level,
    output logic [3:0]                         aux_level
);
    import mic_pkg::*;

    mic_pwm_if pwm ();

    logic [7:0]      intensity_reg;
    logic [7:0]      intensity_next;
    mic_osc_t        osc_reg;
    mic_osc_t        osc_next;
    logic [3:0]      slot_reg;
    logic [3:0]      slot_next;
    logic [3:0]      sub_reg;
    logic [3:0]      sub_next;
    logic [7:0]      rdata_reg;
    logic [7:0]      rdata_next;
    logic            rvalid_reg;
    logic            hit_reg;
    logic            hit_next;
    logic [PORTS:0]  drive_reg;

    wire             addr_match;
    wire             wr_hit;
    wire             rd_hit;
    wire [3:0]       master_wr;
    wire [3:0]       aux_wr;
    wire [7:0]       stored_word;
    wire [3:0]       master_now;
    wire [3:0]       aux_now;
    wire             master_zero;
    wire [3:0]       master_next;
    wire             master_zero_next;
    wire             sub_wrap;
    wire             slot_wrap;
    wire             start_osc;
    wire             hold_frame;
    wire [3:0]       sub_inc;
    wire [3:0]       slot_inc;
    mic_mode_t       mode;
    wire [PORTS:0]   drive_comb;

    // register decode, only the new address is claimed
    assign addr_match = (reg_addr == INTENSITY_ADDR);
    assign wr_hit     = reg_wr && addr_match;
    assign rd_hit     = reg_rd && addr_match;

    assign master_now  = intensity_reg[MASTER_MSB:MASTER_LSB];
    assign aux_now     = intensity_reg[AUX_MSB:AUX_LSB];
    assign master_zero = (master_now == MASTER_STOP);

    // write path, master in high nibble, aux in low nibble
    assign master_wr      = reg_wdata[MASTER_MSB:MASTER_LSB];
    assign aux_wr         = reg_wdata[AUX_MSB:AUX_LSB];
    assign intensity_next = wr_hit ? {master_wr, aux_wr} : intensity_reg;

    // read path returns stored fields unchanged
    assign stored_word = {master_now, aux_now};
    assign rdata_next  = rd_hit ? stored_word : READ_IDLE;
    assign hit_next    = (reg_wr || reg_rd) && addr_match;

    // oscillator control, a write of master zero stops it on its own edge
    assign master_next      = intensity_next[MASTER_MSB:MASTER_LSB];
    assign master_zero_next = (master_next == MASTER_STOP);
    assign start_osc        = (osc_reg == MIC_OSC_STOPPED) && !master_zero;

    always_comb begin
        osc_next = osc_reg;
        unique case (osc_reg)
            MIC_OSC_STOPPED: begin
                // start one clock after a nonzero master lands
                if (!master_zero && !master_zero_next) begin
                    osc_next = MIC_OSC_RUNNING;
                end
            end
            MIC_OSC_RUNNING: begin
                // stop on the same edge that stores master zero
                if (master_zero_next) begin
                    osc_next = MIC_OSC_STOPPED;
                end
            end
        endcase
    end

    // frame counters, held at zero while stopped
    assign sub_wrap   = (sub_reg == SUB_LAST);
    assign slot_wrap  = (slot_reg == SLOT_LAST);
    assign hold_frame = (osc_reg == MIC_OSC_STOPPED) || master_zero || start_osc;
    assign sub_inc    = sub_reg + 4'h1;
    assign slot_inc   = slot_reg + 4'h1;

    always_comb begin
        sub_next  = sub_reg;
        slot_next = slot_reg;
        if (hold_frame) begin
            sub_next  = SUB_FIRST;
            slot_next = SLOT_FIRST;
        end else if (sub_wrap) begin
            sub_next  = SUB_FIRST;
            slot_next = slot_wrap ? SLOT_FIRST : slot_inc;
        end else begin
            sub_next  = sub_inc;
        end
    end

    // shared timing to the duty generators
    assign pwm.slot    = slot_reg;
    assign pwm.sub     = sub_reg;
    assign pwm.master  = master_now;
    assign pwm.running = (osc_reg == MIC_OSC_RUNNING) && !master_zero;

    // global flag selects the aux nibble for every output
    assign mode = global_enable ? MIC_MODE_GLOBAL : MIC_MODE_INDIVIDUAL;

    // one duty generator per port, the last one is the seventeenth output
    genvar gi;
    generate
        for (gi = 0; gi <= PORTS; gi++) begin : g_out
            wire [3:0] sel_level;
            if (gi == PORTS) begin : g_aux
                // seventeenth output always runs from the aux nibble
                assign sel_level = aux_now;
            end else begin : g_port
                assign sel_level = (mode == MIC_MODE_GLOBAL) ?
                                   aux_now :
                                   port_level[gi*4 +: 4];
            end
            mic_duty_gen u_duty (
                .pwm       (pwm),
                .level     (sel_level),
                .out_level (out_level[gi]),
                .drive     (drive_comb[gi])
            );
        end
    endgenerate

    // state
    always_ff @(posedge clk) begin
        if (srst) begin
            intensity_reg <= INTENSITY_RESET;
            osc_reg       <= MIC_OSC_STOPPED;
        end else begin
            intensity_reg <= intensity_next;
            osc_reg       <= osc_next;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            slot_reg <= SLOT_FIRST;
            sub_reg  <= SUB_FIRST;
        end else begin
            slot_reg <= slot_next;
            sub_reg  <= sub_next;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg  <= READ_IDLE;
            rvalid_reg <= 1'b0;
            hit_reg    <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= reg_rd;
            hit_reg    <= hit_next;
        end
    end

    // every drive leaves through its own flip-flop
    always_ff @(posedge clk) begin
        if (srst) begin
            drive_reg <= '0;
        end else begin
            drive_reg <= drive_comb;
        end
    end

    // outputs, pwm_running mirrors the oscillator state register
    assign reg_rdata          = rdata_reg;
    assign reg_rvalid         = rvalid_reg;
    assign reg_hit            = hit_reg;
    assign port_drive         = drive_reg[PORTS-1:0];
    assign seventeenth_output = drive_reg[PORTS];
    assign pwm_running        = (osc_reg == MIC_OSC_RUNNING);
    assign master_level       = master_now;
    assign aux_level          = aux_now;

endmodule

// ### inc/mic_pkg.sv
package mic_pkg;

    localparam int          NIBBLE_W        = 4;
    localparam int          DATA_W          = 8;
    localparam int          PORT_COUNT      = 16;

    // register map
    localparam logic [7:0]  INTENSITY_ADDR  = 8'h0e;
    localparam logic [7:0]  INTENSITY_RESET = 8'h00;
    localparam logic [7:0]  READ_IDLE       = 8'h00;

    // field layout
    localparam int          MASTER_MSB      = 7;
    localparam int          MASTER_LSB      = 4;
    localparam int          AUX_MSB         = 3;
    localparam int          AUX_LSB         = 0;

    // special codes
    localparam logic [3:0]  MASTER_STOP     = 4'h0;
    localparam logic [3:0]  LEVEL_STATIC    = 4'hf;

    // pwm frame: 15 master slots of 16 sub-steps each
    localparam logic [3:0]  SLOT_FIRST      = 4'h0;
    localparam logic [3:0]  SLOT_LAST       = 4'he;
    localparam logic [3:0]  SUB_FIRST       = 4'h0;
    localparam logic [3:0]  SUB_LAST        = 4'hf;

    typedef enum logic {
        MIC_OSC_STOPPED,
        MIC_OSC_RUNNING
    } mic_osc_t;

    typedef enum logic {
        MIC_MODE_INDIVIDUAL,
        MIC_MODE_GLOBAL
    } mic_mode_t;

endpackage

// ### inc/mic_pwm_if.sv
`timescale 1ns/1ps
interface mic_pwm_if;
    logic [3:0] slot;
    logic [3:0] sub;
    logic [3:0] master;
    logic       running;

    modport src (
        output slot,
        output sub,
        output master,
        output running
    );

    modport sink (
        input  slot,
        input  sub,
        input  master,
        input  running
    );
endinterface

// ### core/mic_duty_gen.sv
`timescale 1ns/1ps
module mic_duty_gen
    import mic_pkg::*;
(
    mic_pwm_if.sink         pwm,
    input  wire logic [3:0] level,
    input  wire logic       out_level,
    output logic            drive
);
    logic master_gate;
    logic sub_gate;
    logic is_static;
    logic pwm_on;

    // slots 0..n-1 of 15 open the gate; code 0 never opens it
    assign master_gate = pwm.running && (pwm.slot < pwm.master);
    // sub-steps 0..n of 16 are on
    assign sub_gate    = (pwm.sub <= level);
    // code f or stopped oscillator: plain logic level
    assign is_static   = (level == LEVEL_STATIC) || !pwm.running;
    assign pwm_on      = is_static ? 1'b1 : (master_gate && sub_gate);
    assign drive       = out_level && pwm_on;
endmodule

// ### sim/mic_intensity_props.sv
`timescale 1ns/1ps
module mic_intensity_props #(
    parameter int PORTS = 16
) (
    input wire logic           clk,
    input wire logic           srst,
    input wire logic [7:0]     reg_addr,
    input wire logic           reg_wr,
    input wire logic [7:0]     reg_wdata,
    input wire logic           reg_rd,
    input wire logic [7:0]     reg_rdata,
    input wire logic           reg_rvalid,
    input wire logic           reg_hit,
    input wire logic [PORTS:0] out_level,
    input wire logic           seventeenth_output,
    input wire logic           pwm_running,
    input wire logic [3:0]     master_level,
    input wire logic [3:0]     aux_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire at_reg = reg_addr == 8'h0e;
    wire acc = reg_wr || reg_rd;
    a_rd_valid: assert property (reg_rd |=> reg_rvalid)
        else $error("no rvalid");
    a_hit_seen: assert property (acc && at_reg |=> reg_hit)
        else $error("no hit");
    a_miss_quiet: assert property (acc && !at_reg |=> !reg_hit)
        else $error("bad hit");
    a_write_fields: assert property (reg_wr && at_reg |=>
        {master_level, aux_level} == $past(reg_wdata)) else $error("bad fields");
    a_miss_keeps: assert property (reg_wr && !at_reg |=>
        $stable(master_level) && $stable(aux_level)) else $error("fields moved");
    a_read_back: assert property (reg_rd && !reg_wr && at_reg |=>
        reg_rdata == {$past(master_level), $past(aux_level)}) else $error("bad rdata");
    a_miss_zero: assert property (reg_rd && !at_reg |=> reg_rdata == 8'h00)
        else $error("miss rdata");
    a_stop_osc: assert property (master_level == 4'h0 |-> !pwm_running)
        else $error("osc runs");
    a_static_out: assert property (master_level == 4'h0 && $past(master_level) == 4'h0
        |=> seventeenth_output == $past(out_level[PORTS])) else $error("not static");
    c_write: cover property (reg_wr && at_reg);
    c_pwm_on: cover property (pwm_running && seventeenth_output);
    c_miss: cover property (reg_rd && !at_reg);
endmodule
bind mic_intensity_top mic_intensity_props #(.PORTS(PORTS)) u_props (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .out_level(out_level), .seventeenth_output(seventeenth_output),
    .pwm_running(pwm_running), .master_level(master_level), .aux_level(aux_level));

// ### sim/mic_host_model.sv
`timescale 1ns/1ps
module mic_host_model (
    input  wire logic clk,
    output logic [7:0] reg_addr,
    output logic       reg_wr,
    output logic [7:0] reg_wdata,
    output logic       reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
    endtask
endmodule

// ### sim/mic_intensity_bench.sv
`timescale 1ns/1ps
module mic_intensity_bench;
    import mic_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
    logic        reg_wr, reg_rd, reg_rvalid, reg_hit, so, pwm_running;
    logic        global_enable = 1'b0;
    logic [63:0] port_level = 64'h0;
    logic [16:0] out_level = 17'h1ffff;
    logic [15:0] port_drive;
    logic [3:0]  master_level, aux_level;
    logic [7:0]  exp_q[$];
    logic [7:0]  fixed[5] = '{8'h00, 8'hf0, 8'h1e, 8'hff, 8'he7};
    int          errors = 0;
    int          tests_run = 0;
    int          seed = 27946;
    initial forever #12.5 clk = ~clk;
    mic_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    mic_intensity_top DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .global_enable(global_enable),
        .port_level(port_level), .out_level(out_level), .port_drive(port_drive),
        .seventeenth_output(so), .pwm_running(pwm_running),
        .master_level(master_level), .aux_level(aux_level));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        chk(8'(exp_q.size()), 8'h00);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    function automatic logic [7:0] on_cnt(input logic [3:0] m, input logic [3:0] l,
                                          input logic       o);
        if (!o)
            return 8'h00;
        return (m == 4'h0 || l == 4'hf) ? 8'hf0 : m * (l + 8'h01);
    endfunction
    task automatic duty(input logic [7:0] d);
        logic [7:0] cnt[17];
        logic [3:0] lv;
        foreach (cnt[j]) begin
            cnt[j] = 8'h00;
        end
        repeat (8) @(negedge clk);
        repeat (240) begin
            @(negedge clk);
            for (int j = 0; j < 16; j++) begin
                cnt[j] += 8'(port_drive[j]);
            end
            cnt[16] += 8'(so);
        end
        chk({master_level, aux_level}, d);
        chk({7'h00, pwm_running}, {7'h00, d[7:4] != 4'h0});
        chk(cnt[16], on_cnt(d[7:4], d[3:0], out_level[16]));
        for (int j = 0; j < 16; j++) begin
            lv = global_enable ? d[3:0] : port_level[j*4 +: 4];
            chk(cnt[j], on_cnt(d[7:4], lv, out_level[j]));
        end
    endtask
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1 && exp_q.size() == 0) begin
            chk({7'h00, reg_rvalid}, 8'h00);
        end else if (reg_rvalid === 1'b1) begin
            chk(reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        #(25 * 20000);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        rd(8'h0e, 8'h00);
        host.wr(8'h0e, 8'h5a);
        rd(8'h0e, 8'h5a);
        host.wr(8'h0f, 8'hff);
        rd(8'h0f, 8'h00);
        rd(8'h0e, 8'h5a);
        for (int i = 0; i < 16; i++) begin
            v = i < 5 ? fixed[i] : 8'($random(seed));
            global_enable = i[0];
            port_level = {$random(seed), $random(seed)};
            out_level = i < 5 ? 17'h1ffff : 17'($random(seed));
            host.wr(8'h0e, v);
            rd(8'h0e, v);
            duty(v);
        end
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        rd(8'h0e, 8'h00);
        chk({7'h00, pwm_running}, 8'h00);
        repeat (3) @(negedge clk);
        tally_and_finish();
    end
endmodule
